// ==== hcc_consts.vh ====
`ifndef HCC_CONSTS_VH
`define HCC_CONSTS_VH
// ==================================================
// register offsets (byte addresses)
`define HCC_OFF_CTRL3 5'h00
`define HCC_OFF_CTRL1 5'h04
`define HCC_OFF_STATUS 5'h08
`define HCC_OFF_CLEAR 5'h0C
`define HCC_OFF_INTEN 5'h10
`define HCC_OFF_DATA 5'h14
`define HCC_OFF_ADDR 5'h18
// ==================================================
// control three fields
`define HCC_C3_DATA_HOLD_EN 0
`define HCC_C3_ADDRESS_HOLD_EN 1
`define HCC_C3_SLAVE_COLLISION_DETECT_EN 2
`define HCC_C3_SDA_HOLD_SELECT 3
`define HCC_C3_BUFFER_OVERWRITE_EN 4
`define HCC_C3_ACK_TIME_STATUS 7
`define HCC_C3_RESET 8'h00
// ==================================================
// control one fields
`define HCC_C1_CKP 4
`define HCC_C1_MODE_LSB 0
`define HCC_C1_RESET 8'h10
`define HCC_MODE_SLAVE7 4'h6
`define HCC_MODE_I2C_MASTER 4'h8
`define HCC_MODE_SPI_MASTER 4'h0
// ==================================================
// status / interrupt bits
`define HCC_ST_BCL 0
`define HCC_ST_RX 1
`define HCC_ST_OVF 2
`define HCC_ST_ADDR 3
`define HCC_ST_W 4
// ==================================================
// timing
`define HCC_CLK_MHZ 50
`define HCC_HOLD_NS 300
`define HCC_HOLD_CYC ((`HCC_HOLD_NS * `HCC_CLK_MHZ + 999) / 1000)
`endif

// ==== hcc_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// two-flop synchroniser
module hcc_sync (
    // clock
    input wire mclk,
    input wire sys_rst,
    // data
    input wire din,
    output reg dout
);
reg stage;
always @(posedge mclk) begin
    if (sys_rst) begin
        stage <= 1'b1;
        dout <= 1'b1;
    end else begin
        stage <= din;
        dout <= stage;
    end
end
endmodule // hcc_sync
`default_nettype wire

// ==== hcc_slave.v ====
`timescale 1ns/1ps
`default_nettype none
`include "hcc_consts.vh"
module hcc_slave (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // avalon-mm slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // i2c pins
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe_n,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    // interrupt
    output wire irq
);
// ==================================================
// pins
wire scl_s;
wire sda_s;
hcc_sync u_scl (.mclk(mclk), .sys_rst(sys_rst), .din(scl_in), .dout(scl_s));
hcc_sync u_sda (.mclk(mclk), .sys_rst(sys_rst), .din(sda_in), .dout(sda_s));
reg scl_d;
reg sda_d;
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
// ==================================================
// registers
reg [7:0] ctrl3;
reg [7:0] ctrl1;
reg [4:0] status;
reg [4:0] inten;
reg [7:0] rx_data;
reg [7:0] tx_data;
reg [6:0] own_addr;
reg ack_time;
wire [3:0] mode = ctrl1[3:0];
wire is_slave = (mode == `HCC_MODE_SLAVE7);
wire master_mode = (mode == `HCC_MODE_I2C_MASTER) ||
    (mode == `HCC_MODE_SPI_MASTER);
wire buffer_overwrite_en_eff = ctrl3[`HCC_C3_BUFFER_OVERWRITE_EN] & ~master_mode;
wire hold_any = ctrl3[`HCC_C3_ADDRESS_HOLD_EN] | ctrl3[`HCC_C3_DATA_HOLD_EN];
reg rd_wait_done;
assign avs_waitrequest = avs_read & ~rd_wait_done;
assign irq = |(status & inten);
// ==================================================
// slave machine
localparam ST_IDLE = 3'h0;
localparam ST_RECV = 3'h1;
localparam ST_ACK = 3'h2;
localparam ST_SEND = 3'h3;
localparam ST_MACK = 3'h4;
reg [2:0] state;
reg [7:0] shift;
reg [3:0] bitcnt;
reg is_addr;
reg reading;
reg sda_drv_low;
reg sda_want_low;
reg scl_hold;
reg [4:0] hold_cnt;
reg ack_ok;
reg rx_full;
localparam [31:0] HOLD_CYC_FULL = `HCC_HOLD_CYC;
wire [4:0] hold_cyc = HOLD_CYC_FULL[4:0];
assign scl_out = 1'b0;
assign scl_oe_n = ~scl_hold;
assign sda_out = 1'b0;
assign sda_oe_n = ~sda_drv_low;
wire wr_hit = avs_write;
wire ckp_set = wr_hit && avs_address == `HCC_OFF_CTRL1 &&
    avs_writedata[`HCC_C1_CKP];
reg [4:0] ev;
always @(posedge mclk) begin
    if (sys_rst) begin
        state <= ST_IDLE;
        shift <= 8'h00;
        bitcnt <= 4'h0;
        is_addr <= 1'b0;
        reading <= 1'b0;
        sda_want_low <= 1'b0;
        scl_hold <= 1'b0;
        ack_ok <= 1'b0;
        ev <= 5'h00;
        rx_data <= 8'h00;
        rx_full <= 1'b0;
        ack_time <= 1'b0;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        scl_d <= scl_s;
        sda_d <= sda_s;
        ev <= 5'h00;
        if (ckp_set)
            scl_hold <= 1'b0;
        if (avs_read && avs_address == `HCC_OFF_DATA)
            rx_full <= 1'b0;
        if (!is_slave || stop_cond) begin
            state <= ST_IDLE;
            sda_want_low <= 1'b0;
            ack_time <= 1'b0;
        end else if (start_cond) begin
            state <= ST_RECV;
            bitcnt <= 4'h0;
            is_addr <= 1'b1;
            sda_want_low <= 1'b0;
        end else if (scl_rise && ctrl3[`HCC_C3_SLAVE_COLLISION_DETECT_EN] &&
                !sda_want_low && !sda_s &&
                (state == ST_SEND)) begin
            ev[`HCC_ST_BCL] <= 1'b1;
            state <= ST_IDLE;
            sda_want_low <= 1'b0;
        end else begin
            case (state)
            ST_RECV: begin
                if (scl_rise) begin
                    shift <= {shift[6:0], sda_s};
                    bitcnt <= bitcnt + 4'h1;
                end
                if (scl_fall && bitcnt == 4'h8) begin
                    ack_time <= hold_any;
                    if (is_addr) begin
                        ack_ok <= (shift[7:1] == own_addr);
                        reading <= shift[0];
                        sda_want_low <= (shift[7:1] == own_addr);
                        if (shift[7:1] == own_addr) begin
                            ev[`HCC_ST_ADDR] <= 1'b1;
                            if (ctrl3[`HCC_C3_ADDRESS_HOLD_EN])
                                scl_hold <= 1'b1;
                        end
                    end else begin
                        ack_ok <= !rx_full || buffer_overwrite_en_eff;
                        sda_want_low <= !rx_full || buffer_overwrite_en_eff;
                        if (!rx_full || buffer_overwrite_en_eff) begin
                            rx_data <= shift;
                            rx_full <= 1'b1;
                            ev[`HCC_ST_RX] <= 1'b1;
                        end else
                            ev[`HCC_ST_OVF] <= 1'b1;
                        if (ctrl3[`HCC_C3_DATA_HOLD_EN])
                            scl_hold <= 1'b1;
                    end
                    state <= ST_ACK;
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    ack_time <= 1'b0;
                    bitcnt <= 4'h0;
                    if (!ack_ok) begin
                        state <= ST_IDLE;
                        sda_want_low <= 1'b0;
                    end else if (is_addr && reading) begin
                        state <= ST_SEND;
                        shift <= tx_data;
                        sda_want_low <= ~tx_data[7];
                        ev[`HCC_ST_W] <= 1'b1;
                        scl_hold <= 1'b1;
                    end else begin
                        state <= ST_RECV;
                        sda_want_low <= 1'b0;
                    end
                    is_addr <= 1'b0;
                end
            end
            ST_SEND: begin
                if (scl_fall) begin
                    bitcnt <= bitcnt + 4'h1;
                    shift <= {shift[6:0], 1'b1};
                    if (bitcnt == 4'h7) begin
                        state <= ST_MACK;
                        sda_want_low <= 1'b0;
                    end else
                        sda_want_low <= ~shift[6];
                end
            end
            ST_MACK: begin
                if (scl_rise)
                    ack_ok <= !sda_s;
                if (scl_fall) begin
                    bitcnt <= 4'h0;
                    if (ack_ok) begin
                        state <= ST_SEND;
                        shift <= tx_data;
                        sda_want_low <= ~tx_data[7];
                        ev[`HCC_ST_W] <= 1'b1;
                        scl_hold <= 1'b1;
                    end else
                        state <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end
end
// ==================================================
// sda hold timer
always @(posedge mclk) begin
    if (sys_rst) begin
        sda_drv_low <= 1'b0;
        hold_cnt <= 5'h00;
    end else begin
        if (scl_fall && ctrl3[`HCC_C3_SDA_HOLD_SELECT])
            hold_cnt <= hold_cyc;
        else if (hold_cnt != 5'h00)
            hold_cnt <= hold_cnt - 5'h01;
        if (hold_cnt == 5'h00 && !(scl_fall && ctrl3[`HCC_C3_SDA_HOLD_SELECT]))
            sda_drv_low <= sda_want_low;
    end
end
// ==================================================
// register access
always @(posedge mclk) begin
    if (sys_rst) begin
        ctrl3 <= `HCC_C3_RESET;
        ctrl1 <= `HCC_C1_RESET;
        status <= 5'h00;
        inten <= 5'h00;
        tx_data <= 8'hFF;
        own_addr <= 7'h00;
    end else begin
        status <= (status & ~((wr_hit && avs_address == `HCC_OFF_CLEAR) ?
            avs_writedata[4:0] : 5'h00)) | ev;
        if (wr_hit) begin
            case (avs_address)
            `HCC_OFF_CTRL3: ctrl3 <= {1'b0, 2'b00, avs_writedata[4:0]};
            `HCC_OFF_CTRL1: ctrl1 <= avs_writedata[7:0];
            `HCC_OFF_INTEN: inten <= avs_writedata[4:0];
            `HCC_OFF_DATA: tx_data <= avs_writedata[7:0];
            `HCC_OFF_ADDR: own_addr <= avs_writedata[7:1];
            default: ;
            endcase
        end
        if (scl_hold && !ckp_set)
            ctrl1[`HCC_C1_CKP] <= 1'b0;
        else if (ckp_set)
            ctrl1[`HCC_C1_CKP] <= 1'b1;
    end
end
always @(posedge mclk) begin
    if (sys_rst)
        rd_wait_done <= 1'b0;
    else
        rd_wait_done <= avs_read & ~rd_wait_done;
    if (sys_rst)
        avs_readdata <= 32'h00000000;
    else if (avs_read && !rd_wait_done) begin
        case (avs_address)
        `HCC_OFF_CTRL3:
            avs_readdata <= {24'h000000, ack_time, 2'b00, ctrl3[4:0]};
        `HCC_OFF_CTRL1: avs_readdata <= {24'h000000, ctrl1};
        `HCC_OFF_STATUS: avs_readdata <= {27'h0000000, status};
        `HCC_OFF_INTEN: avs_readdata <= {27'h0000000, inten};
        `HCC_OFF_DATA: avs_readdata <= {24'h000000, rx_data};
        `HCC_OFF_ADDR: avs_readdata <= {24'h000000, own_addr, 1'b0};
        default: avs_readdata <= 32'h00000000;
        endcase
    end
end
endmodule // hcc_slave
`default_nettype wire

// ==== hcc_slave_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcc_consts.vh"
// ========================================
// port checker of the slave
module hcc_slave_props (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    // pins and interrupt
    input wire logic scl_in,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] c3, ie, fc;
    logic sp;
    wire w3 = avs_write && avs_address == `HCC_OFF_CTRL3;
    wire wi = avs_write && avs_address == `HCC_OFF_INTEN;
    wire rel = avs_write && avs_address == `HCC_OFF_CTRL1
        && avs_writedata[`HCC_C1_CKP];
    // shadow registers and cycles since scl fell
    always_ff @(posedge mclk) begin
        sp <= scl_in;
        if (sys_rst) begin
            c3 <= 8'h00;
            ie <= 8'h00;
            fc <= 8'hFF;
        end else begin
            if (sp && !scl_in) fc <= 8'h01;
            else if (fc != 8'hFF) fc <= fc + 8'h01;
            if (w3) c3 <= avs_writedata[7:0];
            if (wi) ie <= avs_writedata[7:0];
        end
    end
    sequence s_rd3;
        avs_read && avs_address == `HCC_OFF_CTRL3 && c3[1:0] == 2'b00;
    endsequence
    sequence s_irq;
        $rose(irq) && ie == 8'h01;
    endsequence
    property p_rst;
        $fell(sys_rst) |-> scl_oe_n && sda_oe_n && !irq;
    endproperty
    property p_rb7; s_rd3 |=> avs_readdata[31:7] == 25'h0; endproperty
    property p_rel; rel |-> ##[1:6] scl_oe_n; endproperty
    property p_stay; !scl_oe_n && !rel && !$past(rel) |=> !scl_oe_n; endproperty
    property p_sdah;
        c3[`HCC_C3_SDA_HOLD_SELECT] && !scl_in && $changed(sda_oe_n) |-> fc >= 8'h0F;
    endproperty
    property p_coll; s_irq |-> sda_oe_n && scl_oe_n; endproperty
    property p_gate; s_irq |-> c3[`HCC_C3_SLAVE_COLLISION_DETECT_EN]; endproperty
    property p_mask; wi && avs_writedata == 32'h0 |=> !irq; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    a_rb7: assert property (p_rb7) else $error("ack time bit set");
    a_rel: assert property (p_rel) else $error("scl not released");
    a_stay: assert property (p_stay) else $error("hold dropped");
    a_sdah: assert property (p_sdah) else $error("sda hold short");
    a_coll: assert property (p_coll) else $error("bus not idle");
    a_gate: assert property (p_gate) else $error("irq ungated");
    a_mask: assert property (p_mask) else $error("irq not masked");
endmodule // hcc_slave_props
bind hcc_slave hcc_slave_props hcc_slave_props_i (.mclk(mclk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire

// ==== hcc_bm.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// i2c bus master, open-drain drives
module hcc_bm (
    // clock
    input wire logic mclk,
    // wired bus levels
    input wire logic scl,
    input wire logic sda,
    // drives, 0 pulls low
    output var logic m_scl,
    output var logic m_sda
);
    logic slow = 1'b0;
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
    end
    task automatic q(input logic lo);
        repeat (lo && slow ? 12 : 2) @(posedge mclk);
    endtask
    task automatic bio(input logic b, output logic r);
        m_sda <= b;
        q(1'b1);
        m_scl <= 1'b1;
        q(1'b0);
        // slave may stretch the clock
        wait (scl);
        r = sda;
        q(1'b0);
        m_scl <= 1'b0;
        q(1'b1);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bio(tx[i], rx[i]);
        bio(1'b1, ack);
    endtask
    task automatic start;
        m_sda <= 1'b0;
        q(1'b0);
        m_scl <= 1'b0;
        q(1'b1);
    endtask
    task automatic stop;
        m_sda <= 1'b0;
        q(1'b1);
        m_scl <= 1'b1;
        wait (scl);
        q(1'b0);
        m_sda <= 1'b1;
        q(1'b0);
    endtask
endmodule // hcc_bm
`default_nettype wire

// ==== hcc_slave_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcc_consts.vh"
module hcc_slave_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
    wire m_scl, m_sda;
    wire scl = m_scl && scl_oe_n !== 1'b0;
    wire sda = m_sda && sda_oe_n !== 1'b0;
    localparam logic [31:0] rc = {27'h0, 1'b1, `HCC_MODE_SLAVE7};
    int n_errors = 0;
    int n_checks = 0;
    logic [15:0] rs = 16'h0660;
    logic [31:0] rv;
    logic [7:0] rx;
    logic [6:0] oa;
    logic ak, h;
    initial forever #10 mclk = ~mclk;
    hcc_slave hcc_slave_i (.mclk(mclk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
    hcc_bm hcc_bm_i (.mclk(mclk), .scl(scl), .sda(sda), .m_scl(m_scl),
        .m_sda(m_sda));
    // ========================================
    // helpers
    function automatic logic [15:0] xs(input logic [15:0] s);
        s ^= s << 7;
        s ^= s >> 9;
        s ^= s << 8;
        return s;
    endfunction
    function automatic logic [31:0] c3x(input logic [7:0] v);
        return {24'h0, v & 8'h1F};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic hold_rel(input logic at, output logic held);
        int k;
        k = 0;
        while (scl_oe_n !== 1'b0 && k < 600) begin
            @(posedge mclk);
            k++;
        end
        held = k < 600;
        if (held) begin
            repeat (4) @(posedge mclk);
            chk("scl held", 32'h0, 32'(scl_oe_n));
            rd(`HCC_OFF_CTRL3, rv);
            chk("ack time", 32'(at), 32'(rv[7]));
            wr(`HCC_OFF_CTRL1, rc);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge mclk);
        n_errors++;
        final_report;
    end
    // ========================================
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`HCC_OFF_CTRL1, rv);
        chk("ctrl1", 32'h10, rv);
        rd(5'h1C, rv);
        chk("unmapped", 32'h0, rv);
        chk("pin drive", 32'h0, 32'({scl_out, sda_out}));
        wr(`HCC_OFF_CTRL3, 32'h9C);
        rd(`HCC_OFF_CTRL3, rv);
        chk("ctrl3", c3x(8'h9C), rv);
        rs = xs(rs);
        oa = 7'h08 + 7'(rs[5:0]);
        wr(`HCC_OFF_ADDR, 32'({oa, 1'b0}));
        wr(`HCC_OFF_INTEN, 32'h1);
        wr(`HCC_OFF_CTRL1, rc);
        for (int i = 0; i < 2; i++) begin
            hcc_bm_i.slow = i == 0;
            wr(`HCC_OFF_CTRL3, i ? 32'h02 : 32'h0B);
            rs = xs(rs);
            hcc_bm_i.start;
            fork
                hcc_bm_i.xfer({oa, 1'b0}, rx, ak);
                hold_rel(1'b1, h);
            join
            chk("addr hold", 32'h1, 32'(h));
            chk("addr ack", 32'h0, 32'(ak));
            fork
                hcc_bm_i.xfer(rs[7:0], rx, ak);
                hold_rel(1'b1, h);
            join
            chk("data hold", 32'(i == 0), 32'(h));
            rd(`HCC_OFF_DATA, rv);
            chk("rx data", 32'(rs[7:0]), rv);
            hcc_bm_i.stop;
        end
        for (int i = 0; i < 2; i++) begin
            wr(`HCC_OFF_CTRL3, i ? 32'h10 : 32'h00);
            wr(`HCC_OFF_CLEAR, 32'h1F);
            rs = xs(rs);
            hcc_bm_i.start;
            hcc_bm_i.xfer({oa, 1'b0}, rx, ak);
            hcc_bm_i.xfer(rs[7:0], rx, ak);
            hcc_bm_i.xfer(rs[15:8], rx, ak);
            chk("overwrite ack", 32'(i == 0), 32'(ak));
            hcc_bm_i.stop;
            rd(`HCC_OFF_DATA, rv);
            chk("overwrite data", 32'(i ? rs[15:8] : rs[7:0]), rv);
            rd(`HCC_OFF_STATUS, rv);
            chk("overflow", 32'(i == 0), 32'(rv[`HCC_ST_OVF]));
        end
        wr(`HCC_OFF_CTRL1, {27'h0, 1'b1, `HCC_MODE_I2C_MASTER});
        hcc_bm_i.start;
        hcc_bm_i.xfer({oa, 1'b0}, rx, ak);
        hcc_bm_i.stop;
        chk("master mode ack", 32'h1, 32'(ak));
        wr(`HCC_OFF_CTRL1, rc);
        for (int i = 0; i < 2; i++) begin
            wr(`HCC_OFF_CTRL3, i ? 32'h00 : 32'h04);
            wr(`HCC_OFF_DATA, 32'hFF);
            hcc_bm_i.start;
            fork
                hcc_bm_i.xfer({oa, 1'b1}, rx, ak);
                hold_rel(1'b0, h);
            join
            hcc_bm_i.xfer(8'h00, rx, ak);
            hcc_bm_i.stop;
            rd(`HCC_OFF_STATUS, rv);
            chk("collision", 32'(i == 0), 32'(rv[`HCC_ST_BCL]));
            chk("irq", 32'(i == 0), 32'(irq));
            wr(`HCC_OFF_INTEN, 32'h0);
            @(posedge mclk);
            chk("irq masked", 32'h0, 32'(irq));
            wr(`HCC_OFF_INTEN, 32'h1);
            wr(`HCC_OFF_CLEAR, 32'h1F);
            @(posedge mclk);
            chk("irq clear", 32'h0, 32'(irq));
        end
        final_report;
    end
endmodule // hcc_slave_tb
`default_nettype wire
